// file: core/lfp_top.sv
`timescale 1ns/1ps
// Contract
// RL1: each channel has own 8-bit current code
// RL2: all-channel code write sets every channel
// RL3: writing one to bit 6 starts test
// RL4: whole test ends within 52 us
// RL5: test start switches all outputs off
// RL6: each channel driven alone 1.25 us; code drives each for STEP_CYC = 31 cycles of 40 ns, 1.24 us
// RL7: channels with selection off are skipped
// RL8: tested channel disturbed up to 32 us
// RL9: sixteen flags stored when test ends
// RL10: start bit clears when results valid
// RL11: flag registers at 44h and 45h
// RL12: open faults reported over shorts
// RL13: off channels always flag zero
// RL14: low current on channel sets flag
// RL15: high output voltage sets flag
// RL16: overtemperature disables all outputs
// RL17: trip flag in bit 7 while hot
// RL18: outputs restored, trip flag self-clears
// RL19: enable pin low enables, high floats
// RL20: host avoids enable pulsing with group mode
// RL21: reset clears every register to zero
// RL22: host should switch faulty outputs off
// RL23: flag registers ignore host writes
module lfp_top
    import lfp_pkg::*;
#(
    parameter int NCH = NUM_CH
) (
    // clock and reset
    input  wire logic             I_CORE_CLK,
    input  wire logic             I_RESETN,
    // register port
    input  wire logic [7:0]       I_ADDR,
    input  wire logic             I_WR_EN,
    input  wire logic [7:0]       I_WR_DATA,
    output logic      [7:0]       O_RD_DATA,
    // output stage
    input  wire logic             I_OE_N,
    input  wire logic [NCH-1:0]   I_PWM_ON,
    input  wire logic [NCH-1:0]   I_SENSE_OPEN,
    input  wire logic [NCH-1:0]   I_SENSE_SHORT,
    output logic      [NCH-1:0]   O_CH_DRIVE,
    output logic      [NCH-1:0]   O_CH_HIZ,
    output logic      [NCH*8-1:0] O_CH_CODE,
    // temperature comparators
    input  wire logic             I_TEMP_OVER,
    input  wire logic             I_TEMP_COOL,
    // status
    output logic                  O_TEST_BUSY
);
    lfp_state_e     st_r;
    logic [7:0]     iref_r [NCH];
    logic [1:0]     sel_r  [NCH];
    logic           dmbl_r;
    logic [3:0]     ch_r;
    logic [4:0]     cnt_r;
    logic [10:0]    busy_cnt_r;
    logic [NCH-1:0] open_r;
    logic [NCH-1:0] short_r;
    logic [NCH-1:0] tested_r;
    logic [NCH-1:0] flag_r;
    logic [NCH-1:0] flag_nxt;
    logic [NCH-1:0] drive_nxt;
    logic [NCH-1:0] drive_r;
    logic [7:0]     rd_nxt;
    logic [7:0]     rd_r;
    logic           trip;
    logic           start;

    // channel is on when its selection is not off
    function automatic logic ch_on(input logic [1:0] sel);
        return sel != SEL_OFF;
    endfunction

    // pack four channel selections into one register byte
    function automatic logic [7:0] sel_byte(input logic [1:0] s0,
                                            input logic [1:0] s1,
                                            input logic [1:0] s2,
                                            input logic [1:0] s3);
        return {s3, s2, s1, s0};
    endfunction

    assign start = I_WR_EN && (I_ADDR == CTRL2_OFS)
                   && I_WR_DATA[CTRL2_CHECK_BIT] && (st_r == LFP_IDLE); // RL3

    // current codes: per channel and all-channel writes
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            for (int i = 0; i < NCH; i++) begin
                iref_r[i] <= REG_RST; // RL21
            end
        end else if (I_WR_EN && I_ADDR == ALLCODE_OFS) begin
            for (int i = 0; i < NCH; i++) begin
                iref_r[i] <= I_WR_DATA; // RL2
            end
        end else if (I_WR_EN && I_ADDR >= IREF_OFS
                     && I_ADDR < IREF_OFS + 8'(NCH)) begin
            iref_r[4'(I_ADDR - IREF_OFS)] <= I_WR_DATA; // RL1
        end
    end

    // output state selection and group mode bit
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            for (int i = 0; i < NCH; i++) begin
                sel_r[i] <= SEL_OFF; // RL21
            end
            dmbl_r <= 1'b0;
        end else if (I_WR_EN) begin
            if (I_ADDR >= OSEL_OFS && I_ADDR < OSEL_OFS + 8'h04) begin
                for (int j = 0; j < 4; j++) begin
                    sel_r[{2'(I_ADDR - OSEL_OFS), 2'(j)}] <=
                        I_WR_DATA[2*j +: 2];
                end
            end else if (I_ADDR == CTRL2_OFS) begin
                dmbl_r <= I_WR_DATA[CTRL2_GRP_BIT];
            end
        end
    end

    // fault test sequencer
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            st_r     <= LFP_IDLE;
            ch_r     <= 4'h0;
            cnt_r    <= 5'h00;
            tested_r <= '0;
            open_r   <= '0;
            short_r  <= '0;
        end else begin
            case (st_r)
                LFP_IDLE: begin
                    if (start) begin
                        st_r    <= LFP_BLANK; // RL3
                        ch_r    <= 4'h0;
                        cnt_r   <= 5'h00;
                        open_r  <= '0;
                        short_r <= '0;
                        for (int i = 0; i < NCH; i++) begin
                            tested_r[i] <= ch_on(sel_r[i]); // RL7 RL13
                        end
                    end
                end
                LFP_BLANK: begin
                    st_r <= LFP_STEP; // RL5
                end
                LFP_STEP: begin
                    if (!tested_r[ch_r] || cnt_r == 5'(STEP_CYC - 1)) begin
                        if (tested_r[ch_r]) begin
                            open_r[ch_r]  <= I_SENSE_OPEN[ch_r];  // RL14
                            short_r[ch_r] <= I_SENSE_SHORT[ch_r]; // RL15
                        end
                        cnt_r <= 5'h00;
                        ch_r  <= ch_r + 4'h1; // RL7
                        if (ch_r == 4'(NCH - 1)) begin
                            st_r <= LFP_DONE;
                        end
                    end else begin
                        cnt_r <= cnt_r + 5'h01; // RL6
                    end
                end
                LFP_DONE: begin
                    st_r <= LFP_IDLE; // RL10
                end
                default: begin
                    st_r <= LFP_IDLE;
                end
            endcase
        end
    end

    // merge open and short results
    lfp_fault_eval #(
        .N        (NCH)
    ) lfp_fault_eval_inst (
        .i_open   (open_r),
        .i_short  (short_r),
        .i_tested (tested_r),
        .o_flags  (flag_nxt)
    );

    // flags change only at test end or reset
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            flag_r <= '0; // RL11 RL21
        end else if (st_r == LFP_DONE) begin
            flag_r <= flag_nxt; // RL9 RL23
        end
    end

    // thermal trip tracking
    lfp_thermal lfp_thermal_inst (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RESETN),
        .i_over  (I_TEMP_OVER),
        .i_cool  (I_TEMP_COOL),
        .o_trip  (trip)
    );

    // channel drive: test overrides normal, trip forces all off
    always_comb begin
        drive_nxt = '0;
        if (trip) begin
            drive_nxt = '0; // RL16
        end else if (st_r == LFP_STEP) begin
            drive_nxt[ch_r] = tested_r[ch_r]; // RL6 RL8
        end else if (st_r == LFP_IDLE && !start) begin // RL5
            for (int i = 0; i < NCH; i++) begin
                drive_nxt[i] = I_PWM_ON[i] && ch_on(sel_r[i]); // RL18
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt; // RL5
        end
    end

    // read mux, answered one cycle after the address
    always_comb begin
        rd_nxt = 8'h00;
        if (I_ADDR == CTRL2_OFS) begin
            rd_nxt[CTRL2_TRIP_BIT]  = trip; // RL17
            rd_nxt[CTRL2_CHECK_BIT] = (st_r != LFP_IDLE); // RL10
            rd_nxt[CTRL2_GRP_BIT]   = dmbl_r;
        end else if (I_ADDR >= OSEL_OFS && I_ADDR < OSEL_OFS + 8'h04) begin
            rd_nxt = sel_byte(sel_r[{2'(I_ADDR - OSEL_OFS), 2'h0}],
                              sel_r[{2'(I_ADDR - OSEL_OFS), 2'h1}],
                              sel_r[{2'(I_ADDR - OSEL_OFS), 2'h2}],
                              sel_r[{2'(I_ADDR - OSEL_OFS), 2'h3}]);
        end else if (I_ADDR >= IREF_OFS && I_ADDR < IREF_OFS + 8'(NCH)) begin
            rd_nxt = iref_r[4'(I_ADDR - IREF_OFS)];
        end else if (I_ADDR == FLAGLO_OFS) begin
            rd_nxt = flag_r[7:0]; // RL11
        end else if (I_ADDR == FLAGHI_OFS) begin
            rd_nxt = flag_r[15:8]; // RL11
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            rd_r <= 8'h00;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    // busy time measured for the length check
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN || st_r == LFP_IDLE) begin
            busy_cnt_r <= 11'h000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 11'h001;
        end
    end

    // outputs
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            O_CH_CODE[8*i +: 8] = iref_r[i]; // RL1
        end
    end
    assign O_CH_DRIVE  = drive_r & ~{NCH{I_OE_N}}; // RL19
    assign O_CH_HIZ    = {NCH{I_OE_N}}; // RL19
    assign O_RD_DATA   = rd_r;
    assign O_TEST_BUSY = (st_r != LFP_IDLE);

    // checks
    blank_off_a: assert property ( // RL5
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        start |=> drive_r == '0 ##1 drive_r == '0)
        else $error("outputs not off at test start");
    test_len_a: assert property ( // RL4
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        busy_cnt_r < 11'(TEST_MAX_CYC))
        else $error("fault test too long");
    single_ch_a: assert property ( // RL6
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        st_r == LFP_STEP && !trip |=> $onehot0(drive_r))
        else $error("more than one channel under test");
    skip_off_a: assert property ( // RL7
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        st_r == LFP_STEP && !tested_r[ch_r] |=> ch_r != $past(ch_r))
        else $error("off channel not skipped");
    start_clr_a: assert property ( // RL10
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        st_r == LFP_DONE |=> !O_TEST_BUSY && flag_r == $past(flag_nxt))
        else $error("busy bit stale after results");
    off_zero_a: assert property ( // RL13
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        st_r == LFP_DONE |=> (flag_r & ~$past(tested_r)) == '0)
        else $error("off channel flagged");
    open_first_a: assert property ( // RL12
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        st_r == LFP_DONE && |(open_r & tested_r) |=>
            flag_r == $past(open_r & tested_r))
        else $error("short reported with open present");
    trip_off_a: assert property ( // RL16
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        trip |=> drive_r == '0)
        else $error("output driven during trip");
    // reset edge itself clears flags, so it starts no attempt
    flag_ro_a: assert property ( // RL23
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        I_RESETN && st_r != LFP_DONE |=> $stable(flag_r))
        else $error("flags changed outside test end");
    all_code_a: assert property ( // RL2
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == ALLCODE_OFS |=>
            O_CH_CODE == {NCH{$past(I_WR_DATA)}})
        else $error("all-channel code not applied");
endmodule // lfp_top

// file: core/lfp_pkg.sv
package lfp_pkg;
    // register offsets
    localparam logic [7:0] CTRL2_OFS     = 8'h01;
    localparam logic [7:0] OSEL_OFS      = 8'h02;  // four regs, 02h..05h
    localparam logic [7:0] IREF_OFS      = 8'h22;  // sixteen regs
    localparam logic [7:0] ALLCODE_OFS   = 8'h43;
    localparam logic [7:0] FLAGLO_OFS    = 8'h44;
    localparam logic [7:0] FLAGHI_OFS    = 8'h45;
    // second_control_reg fields
    localparam int         CTRL2_TRIP_BIT  = 7;
    localparam int         CTRL2_CHECK_BIT = 6;
    localparam int         CTRL2_GRP_BIT   = 5;
    // reset values
    localparam logic [7:0] REG_RST       = 8'h00;
    localparam logic [1:0] SEL_OFF       = 2'h0;
    // timing at 25 MHz
    localparam int         CLK_NS        = 40;
    localparam int         STEP_NS       = 1250;
    localparam int         STEP_CYC      = STEP_NS / CLK_NS;
    localparam int         TEST_MAX_NS   = 52000;
    localparam int         TEST_MAX_CYC  = TEST_MAX_NS / CLK_NS;
    localparam int         NUM_CH        = 16;
    // fault test sequencer states
    typedef enum logic [3:0] {
        LFP_IDLE  = 4'b0001,
        LFP_BLANK = 4'b0010,
        LFP_STEP  = 4'b0100,
        LFP_DONE  = 4'b1000
    } lfp_state_e;
endpackage

// file: core/lfp_fault_eval.sv
`timescale 1ns/1ps
module lfp_fault_eval #(
    parameter int N = 16
) (
    // captured sense results
    input  wire logic [N-1:0] i_open,
    input  wire logic [N-1:0] i_short,
    input  wire logic [N-1:0] i_tested,
    // merged flags
    output logic      [N-1:0] o_flags
);
    // open faults hide shorts; untested channels always zero
    always_comb begin
        if (|(i_open & i_tested)) begin
            o_flags = i_open & i_tested; // RL12 RL14
        end else begin
            o_flags = i_short & i_tested; // RL15 RL13
        end
    end
endmodule // lfp_fault_eval

// file: core/lfp_thermal.sv
`timescale 1ns/1ps
module lfp_thermal (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // temperature comparators
    input  wire logic i_over,
    input  wire logic i_cool,
    // trip state
    output logic      o_trip
);
    logic trip_r;

    // set above limit, self-clear only below limit minus hysteresis
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            trip_r <= 1'b0;
        end else if (i_over) begin
            trip_r <= 1'b1; // RL16 RL17
        end else if (i_cool) begin
            trip_r <= 1'b0; // RL18
        end
    end

    assign o_trip = trip_r;
endmodule // lfp_thermal

// file: verification/lfp_host_model.sv
`timescale 1ns/1ps
module lfp_host_model (
    // register port side
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_clk,
    output logic      [7:0] o_addr,
    output logic            o_wr_en,
    output logic      [7:0] o_wr_data
);
    logic [7:0] rd_val;
    event       rd_ev;
    // idle bus at time zero
    initial begin
        o_addr = 8'h00;
        o_wr_en = 1'b0;
        o_wr_data = 8'h00;
    end
    // one strobe per byte, stale data not held
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr_en <= 1'b1;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_wr_data <= ~d;
    endtask
    // data settles one edge after the address edge
    task automatic rd(input logic [7:0] a, input bit chk,
                      output logic [7:0] v);
        @(posedge i_clk);
        o_addr <= a;
        @(posedge i_clk);
        @(negedge i_clk);
        v = i_rd_data;
        rd_val = v;
        if (chk) -> rd_ev;
    endtask
endmodule // lfp_host_model

// file: verification/lfp_top_tb.sv
`timescale 1ns/1ps
module lfp_top_tb;
    import lfp_pkg::*;
    // design hookup
    logic         clk, rst_n, wen, oe_n, t_over, t_cool, busy;
    logic [7:0]   addr, wdat, rdat;
    logic [15:0]  pwm, s_open, s_short, drv, hiz;
    logic [127:0] code;
    // bookkeeping
    int           failures, checked, cnt[16];
    logic [7:0]   expq[$];
    logic [31:0]  seed = 32'd17;
    logic [7:0]   v, sel[4], cur[16];
    logic [15:0]  tst, fl, dsave;

    lfp_top lfp_top_inst (.I_CORE_CLK(clk), .I_RESETN(rst_n),
        .I_ADDR(addr), .I_WR_EN(wen), .I_WR_DATA(wdat), .O_RD_DATA(rdat),
        .I_OE_N(oe_n), .I_PWM_ON(pwm), .I_SENSE_OPEN(s_open),
        .I_SENSE_SHORT(s_short), .O_CH_DRIVE(drv), .O_CH_HIZ(hiz),
        .O_CH_CODE(code), .I_TEMP_OVER(t_over), .I_TEMP_COOL(t_cool),
        .O_TEST_BUSY(busy));
    lfp_host_model lfp_host_model_inst (.i_clk(clk), .i_rd_data(rdat),
        .o_addr(addr), .o_wr_en(wen), .o_wr_data(wdat));

    // clock
    initial begin
        clk = 1'b0;
        forever #(CLK_NS / 2) clk = ~clk;
    end
    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // verdict and end of run
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // compare a read byte
    task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR rd_data exp %h got %h", e, g);
        end
    endtask
    // compare an output vector
    task automatic cmp_out(input string n, input logic [127:0] e,
                           input logic [127:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    // host shortcuts
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        lfp_host_model_inst.wr(a, d);
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        lfp_host_model_inst.rd(a, 1'b1, v);
    endtask
    // oldest note against each checked read
    always @(lfp_host_model_inst.rd_ev) begin
        cmp_rd(expq.pop_front(), lfp_host_model_inst.rd_val);
    end
    // per-channel drive time and exclusivity during a test
    always @(negedge clk) if (busy === 1'b1) begin
        cmp_out("drv_alone", 128'(1), 128'($onehot0(drv)));
        for (int i = 0; i < 16; i++) cnt[i] += int'(drv[i]);
    end
    // one fault test with given sense levels
    task automatic fault_run(input logic [15:0] op, input logic [15:0] sh);
        logic [15:0] o, s;
        @(posedge clk);
        s_open <= op;
        s_short <= sh;
        o = op & tst;
        s = sh & tst;
        fl = (o != 16'h0000) ? o : s;
        foreach (cnt[i]) cnt[i] = 0;
        wr(CTRL2_OFS, 8'h40);
        @(posedge clk);
        @(negedge clk);
        cmp_out("busy", 128'(1), 128'(busy));
        v = 8'h40;
        for (int k = 0; k < TEST_MAX_CYC / 2 && v[6] !== 1'b0; k++)
            lfp_host_model_inst.rd(CTRL2_OFS, 1'b0, v);
        rd_exp(CTRL2_OFS, 8'h00);
        rd_exp(FLAGLO_OFS, fl[7:0]);
        rd_exp(FLAGHI_OFS, fl[15:8]);
        for (int i = 0; i < 16; i++)
            cmp_out("step", tst[i] ? 128'(STEP_CYC) : 128'(0),
                    128'(cnt[i]));
    endtask
    // watchdog
    initial begin
        #(CLK_NS * 40000);
        failures++;
        stop_test();
    end
    // main sequence
    initial begin
        {rst_n, t_over, pwm, s_open, s_short} = '0;
        {oe_n, t_cool} = 2'b11;
        failures = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_exp(FLAGLO_OFS, 8'h00);
        rd_exp(FLAGHI_OFS, 8'h00);
        rd_exp(CTRL2_OFS, 8'h00);
        rd_exp(8'h7f, 8'h00);
        cmp_out("code_rst", 0, code);
        v = 8'(rnd());
        wr(ALLCODE_OFS, v);
        @(posedge clk);
        @(negedge clk);
        cmp_out("all_code", {16{v}}, code);
        for (int i = 0; i < 16; i++) begin
            cur[i] = 8'(rnd());
            wr(IREF_OFS + 8'(i), cur[i]);
        end
        @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < 16; i++)
            cmp_out("ch_code", 128'(cur[i]), 128'(code[8*i+:8]));
        wr(FLAGLO_OFS, 8'hff);
        wr(FLAGHI_OFS, 8'hff);
        rd_exp(FLAGLO_OFS, 8'h00);
        rd_exp(FLAGHI_OFS, 8'h00);
        // channels 4..7 left off, the rest random
        for (int k = 0; k < 4; k++) begin
            sel[k] = (k == 1) ? 8'h00 : 8'(rnd());
            wr(OSEL_OFS + 8'(k), sel[k]);
            for (int j = 0; j < 4; j++) tst[4*k+j] = |sel[k][2*j+:2];
        end
        // enable held steady, group mode untouched
        @(posedge clk);
        oe_n <= 1'b0;
        pwm <= 16'(rnd());
        @(negedge clk);
        cmp_out("hiz_on", 0, 128'(hiz));
        fault_run(16'(rnd()), 16'(rnd()));
        fault_run(16'h0000, 16'(rnd()));
        fault_run(16'h0000, 16'h0000);
        fault_run(16'hffff, 16'hffff);
        @(negedge clk);
        dsave = drv;
        @(posedge clk);
        t_over <= 1'b1;
        t_cool <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_out("drv_hot", 0, 128'(drv));
        rd_exp(CTRL2_OFS, 8'h80);
        @(posedge clk);
        t_over <= 1'b0;
        t_cool <= 1'b1;
        repeat (3) @(posedge clk);
        rd_exp(CTRL2_OFS, 8'h00);
        cmp_out("drv_back", 128'(dsave), 128'(drv));
        @(posedge clk);
        oe_n <= 1'b1;
        @(negedge clk);
        cmp_out("hiz_off", 128'(16'hffff), 128'(hiz));
        cmp_out("drv_off", 0, 128'(drv));
        for (int k = 0; k < 4; k++) wr(OSEL_OFS + 8'(k), 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd_exp(FLAGLO_OFS, 8'h00);
        rd_exp(FLAGHI_OFS, 8'h00);
        cmp_out("code_rst", 0, code);
        stop_test();
    end
endmodule // lfp_top_tb
